// ===== hw/bsx_defs.svh
`ifndef BSX_DEFS_SVH
`define BSX_DEFS_SVH

// --------------------------------------------------------------
// register port offsets
// --------------------------------------------------------------
`define BSX_OFS_CMD 4'h0
`define BSX_OFS_IOCTL 4'h1
`define BSX_OFS_PC 4'h2
`define BSX_OFS_BC 4'h3
`define BSX_OFS_DE 4'h4
`define BSX_OFS_PTR_PAIR 4'h5
`define BSX_OFS_AF 4'h6
`define BSX_OFS_INDEX_X 4'h7
`define BSX_OFS_INDEX_Y 4'h8

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define BSX_CMD_START_BIT 0
`define BSX_STOP_BIT 0
`define BSX_STAT_BUSY 0
`define BSX_STAT_SLEEP 1
`define BSX_STAT_STOP 2
`define BSX_STAT_ILLEGAL 3
`define BSX_FLAG_S 7
`define BSX_FLAG_Z 6
`define BSX_FLAG_H 4
`define BSX_FLAG_PV 2
`define BSX_FLAG_N 1
`define BSX_FLAG_C 0

// --------------------------------------------------------------
// opcodes and operand codes
// --------------------------------------------------------------
`define BSX_OP_CB 8'hcb
`define BSX_OP_DD 8'hdd
`define BSX_OP_FD 8'hfd
`define BSX_OP_ED 8'hed
`define BSX_OP_SLEEP2 8'h76
`define BSX_OP_SET_HI 2'h3
`define BSX_OP_SHL_ARITH 5'h04
`define BSX_OP_SHR_ARITH 5'h05
`define BSX_R_MEM 3'h6
`define BSX_SLOT_FLAGS 3'h6
`define BSX_SLOT_A 3'h7

// --------------------------------------------------------------
// internal state counts and reset values
// --------------------------------------------------------------
`define BSX_INT_SHIFT 2'h1
`define BSX_INT_SLEEP 2'h2
`define BSX_RST_BYTE 8'h00
`define BSX_RST_WORD 16'h0000

`endif

// ===== hw/bsx_pkg.sv
package bsx_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_MREAD = 3'h2,
        ST_INT = 3'h3,
        ST_MWRITE = 3'h4,
        ST_SLEEP = 3'h5
    } bsx_state_type;

    typedef enum logic [2:0] {
        FP_FIRST = 3'h0,
        FP_CB = 3'h1,
        FP_DISP = 3'h2,
        FP_OP = 3'h3,
        FP_ED2 = 3'h4
    } bsx_fetch_type;

    typedef enum logic [1:0] {
        BP_IDLE = 2'h0,
        BP_T1 = 2'h1,
        BP_T2 = 2'h2,
        BP_T3 = 2'h3
    } bsx_bus_type;

endpackage

// ===== hw/bsx_alu.sv
`include "bsx_defs.svh"

module bsx_alu (
    input wire logic [7:0] op_in,
    input wire logic [7:0] operand_in,
    input wire logic [7:0] flags_in,
    output logic [7:0] result_out,
    output logic [7:0] flags_out
);

    always_comb begin
        result_out = operand_in;
        flags_out = flags_in;
        if (op_in[7:6] == `BSX_OP_SET_HI) begin
            result_out = operand_in | (8'h01 << op_in[5:3]);
        end else begin
            if (op_in[7:3] == `BSX_OP_SHL_ARITH) begin
                result_out = {operand_in[6:0], 1'b0};
                flags_out[`BSX_FLAG_C] = operand_in[7];
            end else begin
                result_out = {operand_in[7], operand_in[7:1]};
                flags_out[`BSX_FLAG_C] = operand_in[0];
            end
            flags_out[`BSX_FLAG_S] = result_out[7];
            flags_out[`BSX_FLAG_Z] = (result_out == 8'h00);
            flags_out[`BSX_FLAG_PV] = ~(^result_out);
            flags_out[`BSX_FLAG_H] = 1'b0;
            flags_out[`BSX_FLAG_N] = 1'b0;
        end
    end

endmodule

// ===== hw/bsx_bus.sv
`include "bsx_defs.svh"

module bsx_bus (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [15:0] addr_in,
    input wire logic write_in,
    input wire logic [7:0] wdata_in,
    input wire logic sleep_in,
    input wire logic bus_grant_ack_n_in,
    output logic done_out,
    output logic [15:0] addr_out,
    output logic addr_oe_out,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ctrl_oe_out
);

    bsx_pkg::bsx_bus_type phase_r, phase_nxt;
    logic [15:0] addr_nxt;
    logic [7:0] data_nxt;
    logic data_oe_nxt, rd_n_nxt, wr_n_nxt, addr_oe_nxt, ctrl_oe_nxt;

    assign done_out = (phase_r == bsx_pkg::BP_T3);

    // --------------------------------------------------------------
    // three state bus cycle
    // --------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        addr_nxt = addr_out;
        data_nxt = data_out;
        data_oe_nxt = data_oe_out;
        rd_n_nxt = rd_n_out;
        wr_n_nxt = wr_n_out;
        addr_oe_nxt = ~sleep_in;
        ctrl_oe_nxt = sleep_in ? bus_grant_ack_n_in : 1'b1;
        if (start_in && (phase_r == bsx_pkg::BP_IDLE || phase_r == bsx_pkg::BP_T3)) begin
            phase_nxt = bsx_pkg::BP_T1;
            addr_nxt = addr_in;
            data_nxt = wdata_in;
            data_oe_nxt = write_in;
            rd_n_nxt = write_in;
            wr_n_nxt = ~write_in;
        end else begin
            case (phase_r)
                bsx_pkg::BP_T1: begin
                    phase_nxt = bsx_pkg::BP_T2;
                end
                bsx_pkg::BP_T2: begin
                    phase_nxt = bsx_pkg::BP_T3;
                end
                bsx_pkg::BP_T3: begin
                    phase_nxt = bsx_pkg::BP_IDLE;
                    data_oe_nxt = 1'b0;
                    rd_n_nxt = 1'b1;
                    wr_n_nxt = 1'b1;
                end
                default: begin
                    phase_nxt = bsx_pkg::BP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_r <= bsx_pkg::BP_IDLE;
            addr_out <= `BSX_RST_WORD;
            data_out <= `BSX_RST_BYTE;
            data_oe_out <= 1'b0;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            addr_oe_out <= 1'b1;
            ctrl_oe_out <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            addr_out <= addr_nxt;
            data_out <= data_nxt;
            data_oe_out <= data_oe_nxt;
            rd_n_out <= rd_n_nxt;
            wr_n_out <= wr_n_nxt;
            addr_oe_out <= addr_oe_nxt;
            ctrl_oe_out <= ctrl_oe_nxt;
        end
    end

endmodule

// ===== hw/bsx_exec.sv
// Operation
// - set instruction forces chosen bit to one, others kept, result written back
// - set instruction leaves all flags unchanged
// - bit selector 0 is least significant bit, 7 most significant
// - register field picks B C D E H L A; code 110 is pointer pair memory
// - indexed address is index register plus sign-extended displacement
// - left shift moves toward msb, old bit 7 into carry
// - right shift moves toward lsb and keeps bit 7
// - right shift loads old bit 0 into carry
// - shifts set sign and zero flags from result
// - shifts set parity on even result, clear half-carry and subtract
// - set and shifts take 7, 13 or 19 states by operand kind
// - sleep opcode ED 76, at least 8 states, stays until released
// - stop bit 0: sleep halts cpu clock, dma and refresh
// - in sleep address floats, controls high, controls float while grant ack low
// - sleep ends on reset or any interrupt request
// - stop bit 1: system stop also halts serial, timers, clocked serial
// - in system stop halted peripherals cannot end the mode
`include "bsx_defs.svh"

module bsx_exec (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic [15:0] mem_addr_out,
    output logic mem_addr_oe_out,
    input wire logic [7:0] mem_data_in,
    output logic [7:0] mem_data_out,
    output logic mem_data_oe_out,
    output logic mem_rd_n_out,
    output logic mem_wr_n_out,
    output logic mem_ctrl_oe_out,
    input wire logic bus_grant_ack_n_in,
    input wire logic ext_irq_in,
    input wire logic int_irq_in,
    input wire logic periph_irq_in,
    output logic instr_done_out,
    output logic cpu_clk_stop_out,
    output logic dma_halt_out,
    output logic refresh_halt_out,
    output logic periph_halt_out
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    bsx_pkg::bsx_state_type state_r, state_nxt;
    bsx_pkg::bsx_fetch_type fphase_r, fphase_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] index_x_r, index_x_nxt;
    logic [15:0] index_y_r, index_y_nxt;
    logic [7:0] gp_r [0:7];
    logic [7:0] gp_nxt [0:7];
    logic [7:0] op_r, op_nxt;
    logic [7:0] disp_r, disp_nxt;
    logic [7:0] operand_r, operand_nxt;
    logic [1:0] int_cnt_r, int_cnt_nxt;
    logic indexed_r, indexed_nxt;
    logic use_iy_r, use_iy_nxt;
    logic stop_peripherals_bit_r, stop_peripherals_bit_nxt;
    logic illegal_r, illegal_nxt;
    logic sleep_r, sleep_nxt;
    logic stop_mode_r, stop_mode_nxt;
    logic done_r, done_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    logic bus_start, bus_write, bus_done;
    logic [15:0] bus_addr;
    logic [15:0] mem_ptr;
    logic [15:0] pc_inc;
    logic [7:0] alu_result, alu_flags;
    logic wake;
    logic legal_op;

    assign instr_done_out = done_r;
    assign cpu_clk_stop_out = sleep_r;
    assign dma_halt_out = sleep_r;
    assign refresh_halt_out = sleep_r;
    assign periph_halt_out = stop_mode_r;
    assign reg_rdata_out = rdata_r;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    assign pc_inc = pc_r + 16'h0001;
    assign mem_ptr = indexed_r ? ((use_iy_r ? index_y_r : index_x_r) + {{8{disp_r[7]}}, disp_r})
                               : {gp_r[3'h4], gp_r[3'h5]};
    assign wake = ext_irq_in | int_irq_in | (periph_irq_in & ~stop_mode_r);
    assign legal_op = (mem_data_in[7:6] == `BSX_OP_SET_HI) || (mem_data_in[7:3] == `BSX_OP_SHL_ARITH)
                      || (mem_data_in[7:3] == `BSX_OP_SHR_ARITH);

    bsx_alu u_alu (
        .op_in(op_r),
        .operand_in(operand_r),
        .flags_in(gp_r[`BSX_SLOT_FLAGS]),
        .result_out(alu_result),
        .flags_out(alu_flags)
    );

    bsx_bus u_bus (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(bus_start),
        .addr_in(bus_addr),
        .write_in(bus_write),
        .wdata_in(alu_result),
        .sleep_in(sleep_r),
        .bus_grant_ack_n_in(bus_grant_ack_n_in),
        .done_out(bus_done),
        .addr_out(mem_addr_out),
        .addr_oe_out(mem_addr_oe_out),
        .data_out(mem_data_out),
        .data_oe_out(mem_data_oe_out),
        .rd_n_out(mem_rd_n_out),
        .wr_n_out(mem_wr_n_out),
        .ctrl_oe_out(mem_ctrl_oe_out)
    );

    // --------------------------------------------------------------
    // sequencer and register file
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        fphase_nxt = fphase_r;
        pc_nxt = pc_r;
        index_x_nxt = index_x_r;
        index_y_nxt = index_y_r;
        for (int i = 0; i < 8; i++) begin
            gp_nxt[i] = gp_r[i];
        end
        op_nxt = op_r;
        disp_nxt = disp_r;
        operand_nxt = operand_r;
        int_cnt_nxt = int_cnt_r;
        indexed_nxt = indexed_r;
        use_iy_nxt = use_iy_r;
        stop_peripherals_bit_nxt = stop_peripherals_bit_r;
        illegal_nxt = illegal_r;
        sleep_nxt = sleep_r;
        stop_mode_nxt = stop_mode_r;
        done_nxt = 1'b0;
        bus_start = 1'b0;
        bus_write = 1'b0;
        bus_addr = pc_inc;
        if (reg_wr_in && state_r == bsx_pkg::ST_IDLE) begin
            case (reg_addr_in)
                `BSX_OFS_CMD: begin
                    if (reg_wdata_in[`BSX_CMD_START_BIT]) begin
                        state_nxt = bsx_pkg::ST_FETCH;
                        fphase_nxt = bsx_pkg::FP_FIRST;
                        indexed_nxt = 1'b0;
                        illegal_nxt = 1'b0;
                        bus_start = 1'b1;
                        bus_addr = pc_r;
                    end
                end
                `BSX_OFS_IOCTL: stop_peripherals_bit_nxt = reg_wdata_in[`BSX_STOP_BIT];
                `BSX_OFS_PC: pc_nxt = reg_wdata_in;
                `BSX_OFS_BC: begin
                    gp_nxt[3'h0] = reg_wdata_in[15:8];
                    gp_nxt[3'h1] = reg_wdata_in[7:0];
                end
                `BSX_OFS_DE: begin
                    gp_nxt[3'h2] = reg_wdata_in[15:8];
                    gp_nxt[3'h3] = reg_wdata_in[7:0];
                end
                `BSX_OFS_PTR_PAIR: begin
                    gp_nxt[3'h4] = reg_wdata_in[15:8];
                    gp_nxt[3'h5] = reg_wdata_in[7:0];
                end
                `BSX_OFS_AF: begin
                    gp_nxt[`BSX_SLOT_A] = reg_wdata_in[15:8];
                    gp_nxt[`BSX_SLOT_FLAGS] = reg_wdata_in[7:0];
                end
                `BSX_OFS_INDEX_X: index_x_nxt = reg_wdata_in;
                `BSX_OFS_INDEX_Y: index_y_nxt = reg_wdata_in;
                default: begin
                end
            endcase
        end
        case (state_r)
            bsx_pkg::ST_FETCH: begin
                if (bus_done) begin
                    pc_nxt = pc_inc;
                    case (fphase_r)
                        bsx_pkg::FP_FIRST: begin
                            if (mem_data_in == `BSX_OP_CB) begin
                                fphase_nxt = bsx_pkg::FP_OP;
                                bus_start = 1'b1;
                            end else if (mem_data_in == `BSX_OP_DD || mem_data_in == `BSX_OP_FD) begin
                                indexed_nxt = 1'b1;
                                use_iy_nxt = (mem_data_in == `BSX_OP_FD);
                                fphase_nxt = bsx_pkg::FP_CB;
                                bus_start = 1'b1;
                            end else if (mem_data_in == `BSX_OP_ED) begin
                                fphase_nxt = bsx_pkg::FP_ED2;
                                bus_start = 1'b1;
                            end else begin
                                illegal_nxt = 1'b1;
                                state_nxt = bsx_pkg::ST_IDLE;
                                done_nxt = 1'b1;
                            end
                        end
                        bsx_pkg::FP_CB: begin
                            if (mem_data_in == `BSX_OP_CB) begin
                                fphase_nxt = bsx_pkg::FP_DISP;
                                bus_start = 1'b1;
                            end else begin
                                illegal_nxt = 1'b1;
                                state_nxt = bsx_pkg::ST_IDLE;
                                done_nxt = 1'b1;
                            end
                        end
                        bsx_pkg::FP_DISP: begin
                            disp_nxt = mem_data_in;
                            fphase_nxt = bsx_pkg::FP_OP;
                            bus_start = 1'b1;
                        end
                        bsx_pkg::FP_OP: begin
                            op_nxt = mem_data_in;
                            if (!legal_op || (indexed_r && mem_data_in[2:0] != `BSX_R_MEM)) begin
                                illegal_nxt = 1'b1;
                                state_nxt = bsx_pkg::ST_IDLE;
                                done_nxt = 1'b1;
                            end else if (mem_data_in[2:0] == `BSX_R_MEM) begin
                                state_nxt = bsx_pkg::ST_MREAD;
                                bus_start = 1'b1;
                                bus_addr = mem_ptr;
                            end else begin
                                operand_nxt = gp_r[mem_data_in[2:0]];
                                state_nxt = bsx_pkg::ST_INT;
                                int_cnt_nxt = `BSX_INT_SHIFT;
                            end
                        end
                        bsx_pkg::FP_ED2: begin
                            if (mem_data_in == `BSX_OP_SLEEP2) begin
                                state_nxt = bsx_pkg::ST_INT;
                                int_cnt_nxt = `BSX_INT_SLEEP;
                            end else begin
                                illegal_nxt = 1'b1;
                                state_nxt = bsx_pkg::ST_IDLE;
                                done_nxt = 1'b1;
                            end
                        end
                        default: begin
                            state_nxt = bsx_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            bsx_pkg::ST_MREAD: begin
                if (bus_done) begin
                    operand_nxt = mem_data_in;
                    state_nxt = bsx_pkg::ST_INT;
                    int_cnt_nxt = `BSX_INT_SHIFT;
                end
            end
            bsx_pkg::ST_INT: begin
                int_cnt_nxt = int_cnt_r - 2'h1;
                if (int_cnt_r == 2'h1) begin
                    if (fphase_r == bsx_pkg::FP_ED2) begin
                        state_nxt = bsx_pkg::ST_SLEEP;
                        sleep_nxt = 1'b1;
                        stop_mode_nxt = stop_peripherals_bit_r;
                    end else begin
                        gp_nxt[`BSX_SLOT_FLAGS] = alu_flags;
                        if (op_r[2:0] == `BSX_R_MEM) begin
                            state_nxt = bsx_pkg::ST_MWRITE;
                            bus_start = 1'b1;
                            bus_write = 1'b1;
                            bus_addr = mem_ptr;
                        end else begin
                            gp_nxt[op_r[2:0]] = alu_result;
                            state_nxt = bsx_pkg::ST_IDLE;
                            done_nxt = 1'b1;
                        end
                    end
                end
            end
            bsx_pkg::ST_MWRITE: begin
                if (bus_done) begin
                    state_nxt = bsx_pkg::ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            bsx_pkg::ST_SLEEP: begin
                if (wake) begin
                    state_nxt = bsx_pkg::ST_IDLE;
                    sleep_nxt = 1'b0;
                    stop_mode_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= bsx_pkg::ST_IDLE;
            fphase_r <= bsx_pkg::FP_FIRST;
            pc_r <= `BSX_RST_WORD;
            index_x_r <= `BSX_RST_WORD;
            index_y_r <= `BSX_RST_WORD;
            for (int i = 0; i < 8; i++) begin
                gp_r[i] <= `BSX_RST_BYTE;
            end
            op_r <= `BSX_RST_BYTE;
            disp_r <= `BSX_RST_BYTE;
            operand_r <= `BSX_RST_BYTE;
            int_cnt_r <= 2'h0;
            indexed_r <= 1'b0;
            use_iy_r <= 1'b0;
            stop_peripherals_bit_r <= 1'b0;
            illegal_r <= 1'b0;
            sleep_r <= 1'b0;
            stop_mode_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fphase_r <= fphase_nxt;
            pc_r <= pc_nxt;
            index_x_r <= index_x_nxt;
            index_y_r <= index_y_nxt;
            for (int i = 0; i < 8; i++) begin
                gp_r[i] <= gp_nxt[i];
            end
            op_r <= op_nxt;
            disp_r <= disp_nxt;
            operand_r <= operand_nxt;
            int_cnt_r <= int_cnt_nxt;
            indexed_r <= indexed_nxt;
            use_iy_r <= use_iy_nxt;
            stop_peripherals_bit_r <= stop_peripherals_bit_nxt;
            illegal_r <= illegal_nxt;
            sleep_r <= sleep_nxt;
            stop_mode_r <= stop_mode_nxt;
            done_r <= done_nxt;
        end
    end

    // --------------------------------------------------------------
    // register read port
    // --------------------------------------------------------------
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `BSX_OFS_CMD: begin
                    rdata_nxt[`BSX_STAT_BUSY] = (state_r != bsx_pkg::ST_IDLE);
                    rdata_nxt[`BSX_STAT_SLEEP] = sleep_r;
                    rdata_nxt[`BSX_STAT_STOP] = stop_mode_r;
                    rdata_nxt[`BSX_STAT_ILLEGAL] = illegal_r;
                end
                `BSX_OFS_IOCTL: rdata_nxt[`BSX_STOP_BIT] = stop_peripherals_bit_r;
                `BSX_OFS_PC: rdata_nxt = pc_r;
                `BSX_OFS_BC: rdata_nxt = {gp_r[3'h0], gp_r[3'h1]};
                `BSX_OFS_DE: rdata_nxt = {gp_r[3'h2], gp_r[3'h3]};
                `BSX_OFS_PTR_PAIR: rdata_nxt = {gp_r[3'h4], gp_r[3'h5]};
                `BSX_OFS_AF: rdata_nxt = {gp_r[`BSX_SLOT_A], gp_r[`BSX_SLOT_FLAGS]};
                `BSX_OFS_INDEX_X: rdata_nxt = index_x_r;
                `BSX_OFS_INDEX_Y: rdata_nxt = index_y_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

endmodule

// ===== tb/bsx_exec_props.sv
module bsx_exec_props (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic mem_addr_oe_out,
    input wire logic mem_ctrl_oe_out,
    input wire logic bus_grant_ack_n_in,
    input wire logic ext_irq_in,
    input wire logic int_irq_in,
    input wire logic periph_irq_in,
    input wire logic instr_done_out,
    input wire logic cpu_clk_stop_out,
    input wire logic dma_halt_out,
    input wire logic refresh_halt_out,
    input wire logic periph_halt_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic stp;
    logic w;
    assign stp = cpu_clk_stop_out;
    assign w = ext_irq_in | int_irq_in;
    property p_tie; stp == dma_halt_out && stp == refresh_halt_out; endproperty
    a_tie: assert property (p_tie) else $error("halt outputs differ");
    property p_sys; periph_halt_out |-> stp; endproperty
    a_sys: assert property (p_sys) else $error("stop without halt");
    property p_addr; stp && $past(stp) |-> !mem_addr_oe_out; endproperty
    a_addr: assert property (p_addr) else $error("address driven");
    property p_ctl; $past(stp, 2) && stp && $stable(bus_grant_ack_n_in) |-> mem_ctrl_oe_out == bus_grant_ack_n_in;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control enable wrong");
    property p_wake; stp && w |=> instr_done_out && !stp; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_pwake; stp && !periph_halt_out && periph_irq_in |=> !stp; endproperty
    a_pwake: assert property (p_pwake) else $error("no peripheral wake");
    property p_stay; stp && !w && !periph_irq_in |=> stp; endproperty
    a_stay: assert property (p_stay) else $error("left sleep");
    property p_hold; periph_halt_out && !w |=> stp; endproperty
    a_hold: assert property (p_hold) else $error("peripheral ended stop");
    c_wake: cover property (stp && w);
    c_stop: cover property (periph_halt_out && periph_irq_in);
    c_float: cover property (stp && !mem_ctrl_oe_out);
endmodule

bind bsx_exec bsx_exec_props bsx_exec_props_inst (.*);

// ===== tb/bsx_mem_model.sv
module bsx_mem_model (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] m [256];
    logic [7:0] last_r = 8'h00;
    // released bus shows inverse of last byte
    assign data_out = rd_n_in ? ~last_r : m[addr_in[7:0]];
    always @(posedge clk_in) begin
        if (!rd_n_in)
            last_r <= m[addr_in[7:0]];
        if (!wr_n_in)
            m[addr_in[7:0]] <= data_in;
    end
endmodule

// ===== tb/bsx_exec_bench.sv
module bsx_exec_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, bus_grant_ack_n_in = 1;
    logic ext_irq_in = 0, int_irq_in = 0, periph_irq_in = 0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, mem_addr_out;
    logic [7:0] mem_data_in, mem_data_out;
    logic mem_addr_oe_out, mem_data_oe_out, mem_rd_n_out, mem_wr_n_out, mem_ctrl_oe_out, instr_done_out;
    logic cpu_clk_stop_out, dma_halt_out, refresh_halt_out, periph_halt_out;
    int errors = 0, n_tests = 0, k, cyc = 0;
    logic [7:0] prog [20] = '{8'hcb, 8'h20, 8'hcb, 8'h2e, 8'hdd, 8'hcb, 8'hff, 8'hc6, 8'hcb, 8'hff, 8'hed, 8'h76,
        8'hed, 8'h76, 8'hed, 8'h76, 8'hfd, 8'hcb, 8'h01, 8'h26};
    bsx_exec bsx_exec_inst (.*);
    bsx_mem_model bsx_mem_model_inst (.clk_in(clk_in), .addr_in(mem_addr_out), .data_in(mem_data_out),
        .rd_n_in(mem_rd_n_out | ~mem_ctrl_oe_out), .wr_n_in(mem_wr_n_out | ~mem_ctrl_oe_out), .data_out(mem_data_in));
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end
    task complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 cmp(reg_rdata_out, e);
    endtask
    task wt(input bit s);
        k = 0;
        do begin
            @(posedge clk_in);
            #1 k++;
        end while ((s ? cpu_clk_stop_out : instr_done_out) !== 1'b1 && k < 400);
    endtask
    task run(input int n);
        wr(4'h0, 16'h0001);
        wt(0);
        cmp(16'(k), 16'(n));
        $display("test %0d ends after %0d cycles", n_tests, k);
    endtask
    initial begin
        foreach (prog[i]) bsx_mem_model_inst.m[i] = prog[i];
        bsx_mem_model_inst.m[8'h40] = 8'h80;
        bsx_mem_model_inst.m[8'h80] = 8'h00;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(4'h1, 16'h0000);
        rd(4'hf, 16'h0000);
        wr(4'h3, 16'h8100);
        wr(4'h6, 16'h00ff);
        wr(4'h5, 16'h0040);
        wr(4'h7, 16'h0081);
        run(7);
        rd(4'h3, 16'h0200);
        rd(4'h6, 16'h0029);
        run(13);
        cmp(16'(bsx_mem_model_inst.m[8'h40]), 16'h00c0);
        rd(4'h6, 16'h00ac);
        run(19);
        cmp(16'(bsx_mem_model_inst.m[8'h80]), 16'h0001);
        run(7);
        rd(4'h6, 16'h80ac);
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0001);
        wt(1);
        cmp(16'(k), 16'h0008);
        cmp(16'(periph_halt_out), 16'h0000);
        @(posedge clk_in);
        bus_grant_ack_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        bus_grant_ack_n_in <= 1'b1;
        ext_irq_in <= 1'b1;
        #1 cmp(16'(mem_ctrl_oe_out), 16'h0000);
        wt(0);
        cmp(16'(k), 16'h0001);
        @(posedge clk_in);
        ext_irq_in <= 1'b0;
        wr(4'h1, 16'h0001);
        wr(4'h0, 16'h0001);
        wt(1);
        cmp(16'(periph_halt_out), 16'h0001);
        @(posedge clk_in);
        periph_irq_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        int_irq_in <= 1'b1;
        #1 cmp(16'(cpu_clk_stop_out), 16'h0001);
        wt(0);
        cmp(16'(cpu_clk_stop_out), 16'h0000);
        @(posedge clk_in);
        int_irq_in <= 1'b0;
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0001);
        wt(1);
        wt(0);
        cmp(16'(k), 16'h0001);
        wr(4'h8, 16'h003f);
        run(19);
        cmp(16'(bsx_mem_model_inst.m[8'h40]), 16'h0080);
        rd(4'h6, 16'h80a9);
        complete_run();
    end
endmodule
